//--- tssr_device.sv
// Sensor end of the serial link: output data registers and the frame engine.
// Assumes sample values arrive on aclk with a one-cycle sample strobe.
`timescale 1ns/1ps
`default_nettype none
module tssr_device
	import tssr_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	tssr_spi_if.dev          spi,
	input  wire logic        sample_stb,
	input  wire logic [11:0] supply_in,
	input  wire logic [11:0] aux_in,
	input  wire logic [11:0] temp_in,
	input  wire logic [13:0] tilt_full_in,
	input  wire logic [13:0] tilt_signed_in,
	input  wire logic        alarm_in,
	output logic             wr_stb,
	output logic [5:0]       wr_addr,
	output logic [7:0]       wr_data
);

	typedef enum logic [1:0] {
		TSSR_D_IDLE = 2'b01,
		TSSR_D_XFER = 2'b10
	} tssr_dstate_t;

	// Synchroniser stages, bit 0 chip select, bit 1 clock, bit 2 data in.
	logic [2:0]   sy1_q, sy2_q, sy3_q;
	logic [2:0]   flt_q, flt_d;
	logic [2:0]   stable;
	logic [2:0]   chg;
	tssr_dstate_t state_q, state_d;
	logic [4:0]   cnt_q, cnt_d;
	logic [15:0]  rx_q, rx_d;
	logic [15:0]  tx_q, tx_d;
	logic         oe_q, oe_d;
	logic         pend_q, pend_d;
	logic [2:0]   pidx_q, pidx_d;
	logic [13:0]  data_q [NUM_OUT_REGS];
	logic [13:0]  data_d [NUM_OUT_REGS];
	logic [NUM_OUT_REGS-1:0] nd_q, nd_d;
	logic         alarm_q, alarm_d;
	logic         wr_stb_q, wr_stb_d;
	logic [5:0]   wr_addr_q, wr_addr_d;
	logic [7:0]   wr_data_q, wr_data_d;
	logic         cs_fall, cs_rise, sclk_rise, sclk_fall;
	logic [2:0]   cidx;

	// A line change counts only once the second and third stages agree.
	assign stable    = ~(sy2_q ^ sy3_q);
	assign chg       = stable & (sy3_q ^ flt_q);
	assign cs_fall   = chg[0] & flt_q[0];
	assign cs_rise   = chg[0] & ~flt_q[0];
	assign sclk_rise = chg[1] & ~flt_q[1];
	assign sclk_fall = chg[1] & flt_q[1];
	assign cidx      = tssr_reg_index(rx_q[13:8]);

	always_comb begin
		flt_d     = (flt_q & ~stable) | (sy3_q & stable);
		state_d   = state_q;
		cnt_d     = cnt_q;
		rx_d      = rx_q;
		tx_d      = tx_q;
		oe_d      = oe_q;
		pend_d    = pend_q;
		pidx_d    = pidx_q;
		data_d    = data_q;
		nd_d      = nd_q;
		wr_stb_d  = 1'b0;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		alarm_d   = alarm_in; // [R12]

		// Fresh samples land whatever the host is doing.
		if (sample_stb) begin // [R10]
			data_d[IDX_SUPPLY]      = {2'b00, supply_in}; // [R13] [R14]
			data_d[IDX_AUX]         = {2'b00, aux_in}; // [R15]
			data_d[IDX_TEMP]        = {2'b00, temp_in}; // [R16]
			data_d[IDX_TILT_FULL]   = tilt_full_in; // [R17]
			data_d[IDX_TILT_SIGNED] = tilt_signed_in; // [R18]
		end

		case (state_q)
			TSSR_D_IDLE: begin
				// Clock and data are ignored until chip select falls.
				if (cs_fall) begin // [R1]
					state_d = TSSR_D_XFER;
					cnt_d   = 5'h00;
					oe_d    = 1'b1;
					tx_d    = IDLE_WORD;
					if (pend_q && pidx_q != IDX_NONE) begin // [R6]
						tx_d = {nd_q[pidx_q], alarm_q, data_q[pidx_q]}; // [R11] [R12]
						nd_d[pidx_q] = 1'b0; // [R11]
					end
					pend_d = 1'b0;
				end
			end
			TSSR_D_XFER: begin
				if (cs_rise) begin
					state_d = TSSR_D_IDLE;
					oe_d    = 1'b0; // [R1]
					// A frame short or long of sixteen clocks is dropped.
					if (cnt_q == 5'(FRAME_BITS)) begin // [R2]
						if (rx_q[15:14] == CMD_WRITE) begin // [R3] [R4]
							wr_stb_d  = 1'b1;
							wr_addr_d = rx_q[13:8];
							wr_data_d = rx_q[7:0];
						end else if (rx_q[15:14] == CMD_READ) begin // [R5] [R9]
							pend_d = 1'b1;
							pidx_d = cidx; // [R7] [R8]
						end
					end
				end else begin
					if (sclk_rise) begin // [R20]
						rx_d  = {rx_q[14:0], flt_q[2]}; // [R23]
						cnt_d = (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
					end
					// Bit 15 already stands from the select fall.
					if (sclk_fall && cnt_q != 5'h00) begin // [R21]
						tx_d = {tx_q[14:0], 1'b0}; // [R23]
					end
				end
			end
			default: begin
				state_d = TSSR_D_IDLE;
				oe_d    = 1'b0;
			end
		endcase

		// A sample arriving while a read clears its flag still wins.
		if (sample_stb) begin
			nd_d = '1; // [R11]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin // [R19]
			sy1_q     <= 3'h7;
			sy2_q     <= 3'h7;
			sy3_q     <= 3'h7;
			flt_q     <= 3'h7;
			state_q   <= TSSR_D_IDLE;
			cnt_q     <= 5'h00;
			rx_q      <= 16'h0000;
			tx_q      <= IDLE_WORD;
			oe_q      <= 1'b0;
			pend_q    <= 1'b0;
			pidx_q    <= IDX_NONE;
			nd_q      <= '0;
			alarm_q   <= 1'b0;
			wr_stb_q  <= 1'b0;
			wr_addr_q <= 6'h00;
			wr_data_q <= 8'h00;
			for (int i = 0; i < NUM_OUT_REGS; i++) begin
				data_q[i] <= 14'h0000;
			end
		end else begin
			sy1_q     <= {spi.mosi, spi.sclk, spi.cs_n};
			sy2_q     <= sy1_q;
			sy3_q     <= sy2_q;
			flt_q     <= flt_d;
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			rx_q      <= rx_d;
			tx_q      <= tx_d;
			oe_q      <= oe_d;
			pend_q    <= pend_d;
			pidx_q    <= pidx_d;
			nd_q      <= nd_d;
			alarm_q   <= alarm_d;
			wr_stb_q  <= wr_stb_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
			data_q    <= data_d;
		end
	end

	assign spi.miso_o  = tx_q[15];
	assign spi.miso_oe = oe_q;
	assign wr_stb      = wr_stb_q;
	assign wr_addr     = wr_addr_q;
	assign wr_data     = wr_data_q;

endmodule : tssr_device
`default_nettype wire

//--- tssr_host.sv
// Master end of the serial link, ordered by software over AXI4-Lite.
// Assumes the sensor samples on rising clock edges and answers on falls.
`timescale 1ns/1ps
`default_nettype none
module tssr_host
	import tssr_pkg::*;
#(
	parameter int HALF_CYCLES = SCLK_HALF_CYC,
	parameter int GAP_CYCLES  = GAP_NORMAL_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	tssr_spi_if.host         spi,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	localparam int TW = $clog2(GAP_CYCLES + HALF_CYCLES + 1);

	typedef enum logic [5:0] {
		TSSR_H_IDLE = 6'b000001,
		TSSR_H_LEAD = 6'b000010,
		TSSR_H_LOW  = 6'b000100,
		TSSR_H_HIGH = 6'b001000,
		TSSR_H_TAIL = 6'b010000,
		TSSR_H_GAP  = 6'b100000
	} tssr_hstate_t;

	tssr_hstate_t st_q, st_d;
	logic [TW-1:0] tmr_q, tmr_d;
	logic [4:0]   cnt_q, cnt_d;
	logic [15:0]  tx_q, tx_d, sh_q, sh_d, rx_q, rx_d;
	logic         cs_q, cs_d, sclk_q, sclk_d;
	logic         m1_q, m2_q, m3_q, mf_q, mf_d;
	logic         awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
	logic [1:0]   bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]  rdata_q, rdata_d;
	logic         awh_q, awh_d, wh_q, wh_d;
	logic [7:0]   wa_q, wa_d;
	logic [15:0]  wd_q, wd_d;
	logic         busy;
	logic         start;

	assign busy = (st_q != TSSR_H_IDLE);

	always_comb begin
		awh_d = awh_q;
		wh_d  = wh_q;
		wa_d  = wa_q;
		wd_d  = wd_q;
		bv_d  = bv_q;
		bresp_d = bresp_q;
		rv_d  = rv_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		start = 1'b0;
		if (s_axi_awvalid && awr_q) begin
			awh_d = 1'b1;
			wa_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_q) begin
			wh_d = 1'b1;
			wd_d = s_axi_wdata[15:0];
		end
		if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
		if (awh_q && wh_q && !bv_q) begin
			awh_d   = 1'b0;
			wh_d    = 1'b0;
			bv_d    = 1'b1;
			bresp_d = (wa_q == REG_TX_WORD) ? RESP_OKAY : RESP_SLVERR;
			// An order while a frame runs is accepted and dropped.
			start   = (wa_q == REG_TX_WORD) && !busy;
		end
		if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
		end
		if (s_axi_arvalid && arr_q) begin
			rv_d    = 1'b1;
			rresp_d = RESP_OKAY;
			case (s_axi_araddr)
				REG_TX_WORD: rdata_d = {16'h0000, tx_q};
				REG_STATUS:  rdata_d = {31'h00000000, busy};
				REG_RX_WORD: rdata_d = {16'h0000, rx_q};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
		awr_d = !awh_d && !(awh_q && wh_q);
		wr_d  = !wh_d && !(awh_q && wh_q);
		arr_d = !rv_d;
	end

	always_comb begin
		mf_d   = (m2_q == m3_q) ? m3_q : mf_q;
		st_d   = st_q;
		tmr_d  = (tmr_q == '0) ? tmr_q : tmr_q - TW'(1);
		cnt_d  = cnt_q;
		tx_d   = tx_q;
		sh_d   = sh_q;
		rx_d   = rx_q;
		cs_d   = cs_q;
		sclk_d = sclk_q;
		case (st_q)
			TSSR_H_IDLE: begin
				if (start) begin // [R3] [R5]
					tx_d  = wd_q;
					sh_d  = wd_q; // [R23]
					cs_d  = 1'b0;
					cnt_d = 5'h00;
					tmr_d = TW'(HALF_CYCLES - 1);
					st_d  = TSSR_H_LEAD;
				end
			end
			TSSR_H_LEAD: begin
				if (tmr_q == '0) begin
					sclk_d = 1'b0;
					tmr_d  = TW'(HALF_CYCLES - 1);
					st_d   = TSSR_H_LOW;
				end
			end
			TSSR_H_LOW: begin
				if (tmr_q == '0) begin
					sclk_d = 1'b1;
					sh_d   = {sh_q[15:0]};
					rx_d   = {rx_q[14:0], mf_q}; // [R20] [R23]
					cnt_d  = cnt_q + 5'h01;
					tmr_d  = TW'(HALF_CYCLES - 1);
					st_d   = TSSR_H_HIGH;
				end
			end
			TSSR_H_HIGH: begin
				if (tmr_q == '0) begin
					tmr_d = TW'(HALF_CYCLES - 1);
					if (cnt_q == 5'(FRAME_BITS)) begin // [R2]
						st_d = TSSR_H_TAIL;
					end else begin
						sclk_d = 1'b0; // [R20]
						sh_d   = {sh_q[14:0], 1'b0};
						st_d   = TSSR_H_LOW;
					end
				end
			end
			TSSR_H_TAIL: begin
				if (tmr_q == '0) begin
					cs_d  = 1'b1;
					tmr_d = TW'(GAP_CYCLES - 1);
					st_d  = TSSR_H_GAP;
				end
			end
			TSSR_H_GAP: begin
				if (tmr_q == '0) begin // [R22]
					st_d = TSSR_H_IDLE;
				end
			end
			default: begin
				st_d   = TSSR_H_IDLE;
				cs_d   = 1'b1;
				sclk_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= TSSR_H_IDLE;
			tmr_q <= '0;
			cnt_q <= 5'h00;
			tx_q <= 16'h0000;
			sh_q <= 16'h0000;
			rx_q <= 16'h0000;
			cs_q <= 1'b1;
			sclk_q <= 1'b1;
			m1_q <= 1'b1;
			m2_q <= 1'b1;
			m3_q <= 1'b1;
			mf_q <= 1'b1;
			awr_q <= 1'b0;
			wr_q <= 1'b0;
			bv_q <= 1'b0;
			arr_q <= 1'b0;
			rv_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h00000000;
			awh_q <= 1'b0;
			wh_q <= 1'b0;
			wa_q <= 8'h00;
			wd_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			cnt_q <= cnt_d;
			tx_q <= tx_d;
			sh_q <= sh_d;
			rx_q <= rx_d;
			cs_q <= cs_d;
			sclk_q <= sclk_d;
			m1_q <= spi.miso;
			m2_q <= m1_q;
			m3_q <= m2_q;
			mf_q <= mf_d;
			awr_q <= awr_d;
			wr_q <= wr_d;
			bv_q <= bv_d;
			arr_q <= arr_d;
			rv_q <= rv_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			awh_q <= awh_d;
			wh_q <= wh_d;
			wa_q <= wa_d;
			wd_q <= wd_d;
		end
	end

	assign spi.cs_n = cs_q;
	assign spi.sclk = sclk_q;
	assign spi.mosi = sh_q[15];
	assign s_axi_awready = awr_q;
	assign s_axi_wready  = wr_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

endmodule : tssr_host
`default_nettype wire

//--- tssr_monitor.sv
// Checker for the serial link between host and sensor ends.
// Assumes it sees the link lines on the aclk domain with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tssr_monitor
	import tssr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic miso
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic       sclk_q, sclk_d;
	logic [4:0] rise_q, rise_d;

	// Counts clock rises inside the current frame; cleared while deselected.
	always_comb begin
		sclk_d = sclk;
		rise_d = rise_q;
		if (cs_n)
			rise_d = 5'h00;
		else if (sclk && !sclk_q)
			rise_d = rise_q + 5'h01;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_q <= 1'b1;
			rise_q <= 5'h00;
		end else begin
			sclk_q <= sclk_d;
			rise_q <= rise_d;
		end
	end

	property p_release; cs_n [*8] |-> !miso_oe; endproperty
	a_release: assert property (p_release) else $error("data out driven while deselected");
	property p_drive; $fell(cs_n) |-> ##[1:8] miso_oe; endproperty
	a_drive: assert property (p_drive) else $error("first bit not driven after select");
	property p_out_stable;
		!cs_n && miso_oe && $past(miso_oe) && sclk && $past(sclk) |-> $stable(miso_o);
	endproperty
	a_out_stable: assert property (p_out_stable) else $error("data out moved with clock high");
	property p_in_stable; !cs_n && $past(!cs_n) && sclk && $past(sclk) |-> $stable(mosi); endproperty
	a_in_stable: assert property (p_in_stable) else $error("data in moved with clock high");
	property p_first_hold; $fell(cs_n) |-> sclk [*4]; endproperty
	a_first_hold: assert property (p_first_hold) else $error("clock fell too soon after select");
	property p_idle_high; cs_n |-> sclk; endproperty
	a_idle_high: assert property (p_idle_high) else $error("clock low while deselected");
	property p_frame_len; $rose(cs_n) |-> rise_q == 5'(FRAME_BITS); endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not sixteen clocks");
	property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
	a_gap: assert property (p_gap) else $error("frames too close together");

	c_frame: cover property ($rose(cs_n) && rise_q == 5'(FRAME_BITS));
	c_zero_bit: cover property (miso_oe && !miso);
	c_write_cmd: cover property ($fell(cs_n) ##1 mosi);
endmodule : tssr_monitor
`default_nettype wire

//--- tssr_pkg.sv
// Constants shared by both ends of the tilt sensor serial readout link.
// Assumes a single 200 MHz system clock on each end.
// Functional notes
// R1: Chip select high: output released, clocks ignored.
// R2: Each frame is sixteen clocks, full duplex.
// R3: Write frame: 1, 0, address, eight data.
// R4: One byte per write; register needs two.
// R5: Read frame: 0, 0, address, rest ignored.
// R6: Addressed register returned in following frame.
// R7: Either byte address returns whole register.
// R8: Each register owns two byte addresses.
// R9: Next request may ride the returning frame.
// R10: Output registers refresh at sample rate.
// R11: Bit 15 new sample, cleared on read.
// R12: Bit 14 shows an active alarm.
// R13: Data right aligned, 12 or 14 bits.
// R14: Supply value 12 bit unsigned.
// R15: Auxiliary input value 12 bit unsigned.
// R16: Junction temperature 12 bit unsigned.
// R17: Full circle tilt 14 bit unsigned.
// R18: Signed tilt 14 bit two's complement.
// R19: Reset low returns logic to initial state.
// R20: Clock idles high, sample on rising edge.
// R21: First bit at select fall, rest falls.
// R22: Frames spaced 40 or 100 microseconds apart.
// R23: Both directions shift most significant first.
package tssr_pkg;

	localparam int          FRAME_BITS       = 16;
	localparam int          ND_BIT           = 15;
	localparam int          ALARM_BIT        = 14;
	localparam logic [1:0]  CMD_WRITE        = 2'h2;
	localparam logic [1:0]  CMD_READ         = 2'h0;
	localparam logic [5:0]  ADDR_SUPPLY      = 6'h02;
	localparam logic [5:0]  ADDR_AUX         = 6'h08;
	localparam logic [5:0]  ADDR_TEMP        = 6'h0A;
	localparam logic [5:0]  ADDR_TILT_FULL   = 6'h0C;
	localparam logic [5:0]  ADDR_TILT_SIGNED = 6'h0E;
	localparam int          NUM_OUT_REGS     = 5;
	localparam logic [2:0]  IDX_SUPPLY       = 3'h0;
	localparam logic [2:0]  IDX_AUX          = 3'h1;
	localparam logic [2:0]  IDX_TEMP         = 3'h2;
	localparam logic [2:0]  IDX_TILT_FULL    = 3'h3;
	localparam logic [2:0]  IDX_TILT_SIGNED  = 3'h4;
	localparam logic [2:0]  IDX_NONE         = 3'h7;
	localparam logic [15:0] IDLE_WORD        = 16'h0000;
	localparam int          CLK_MHZ          = 200;
	localparam int          T_SCLK_NS        = 1000;
	localparam int          SCLK_HALF_CYC    = (T_SCLK_NS * CLK_MHZ / 1000 + 1) / 2;
	localparam int          T_GAP_FAST_US    = 40;
	localparam int          T_GAP_NORMAL_US  = 100;
	localparam int          GAP_FAST_CYC     = T_GAP_FAST_US * CLK_MHZ;
	localparam int          GAP_NORMAL_CYC   = T_GAP_NORMAL_US * CLK_MHZ;
	localparam logic [7:0]  REG_TX_WORD      = 8'h00;
	localparam logic [7:0]  REG_STATUS       = 8'h04;
	localparam logic [7:0]  REG_RX_WORD      = 8'h08;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// Both byte addresses of a register map to the same index.
	function automatic logic [2:0] tssr_reg_index(input logic [5:0] addr);
		case ({addr[5:1], 1'b0})
			ADDR_SUPPLY:      tssr_reg_index = IDX_SUPPLY;
			ADDR_AUX:         tssr_reg_index = IDX_AUX;
			ADDR_TEMP:        tssr_reg_index = IDX_TEMP;
			ADDR_TILT_FULL:   tssr_reg_index = IDX_TILT_FULL;
			ADDR_TILT_SIGNED: tssr_reg_index = IDX_TILT_SIGNED;
			default:          tssr_reg_index = IDX_NONE;
		endcase
	endfunction : tssr_reg_index

endpackage : tssr_pkg

//--- tssr_spi_if.sv
// Four-wire serial link between the readout host and the sensor device.
// Assumes both ends run on their own clock and sample every line as a pin.
`timescale 1ns/1ps
`default_nettype none
interface tssr_spi_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;

	// Released data output floats high through a weak pull-up.
	assign miso = miso_oe ? miso_o : 1'b1;

	modport dev  (input cs_n, input sclk, input mosi, output miso_o, output miso_oe);
	modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : tssr_spi_if
`default_nettype wire

//--- tssr_tb.sv
// Self-checking bench: host and sensor ends face each other on one link.
// A second sensor end is driven directly by the bench to break the framing.
`timescale 1ns/1ps
`default_nettype none
module tssr_tb
	import tssr_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0, stb = 1'b0, alarm = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hF;
	logic        awready, wready, bvalid, arready, rvalid, wr_stb, wr_stb2;
	logic [1:0]  bresp, rresp, r;
	logic [11:0] sup = 12'h0, aux = 12'h0, tmp = 12'h0;
	logic [13:0] tf = 14'h0, ts = 14'h0;
	logic [5:0]  wr_addr, wr_addr2;
	logic [7:0]  wr_data, wr_data2, wd;
	logic [15:0] tx, rx;
	logic [31:0] d;
	logic [5:0]  addr_t [7] = '{ADDR_SUPPLY, ADDR_AUX + 6'h01, ADDR_TEMP,
		ADDR_TILT_FULL + 6'h01, ADDR_TILT_SIGNED, ADDR_SUPPLY + 6'h01, 6'h00};
	int          error_cnt = 0, checked = 0, seed, wr_cnt = 0, wr_cnt2 = 0;

	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (wr_stb === 1'b1)
			wr_cnt++;
		if (wr_stb2 === 1'b1)
			wr_cnt2++;
	end

	tssr_spi_if i_tssr_spi_if ();
	tssr_spi_if i_tssr_spi_if_b ();
	// A half period must outlast both ends' synchroniser delays together, eight cycles.
	tssr_host #(.HALF_CYCLES(12), .GAP_CYCLES(20)) i_tssr_host (.aclk(aclk), .aresetn(aresetn),
		.spi(i_tssr_spi_if), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	tssr_device i_tssr_device (.aclk(aclk), .aresetn(aresetn), .spi(i_tssr_spi_if),
		.sample_stb(stb), .supply_in(sup), .aux_in(aux), .temp_in(tmp), .tilt_full_in(tf),
		.tilt_signed_in(ts), .alarm_in(alarm), .wr_stb(wr_stb), .wr_addr(wr_addr),
		.wr_data(wr_data));
	tssr_device i_tssr_device_b (.aclk(aclk), .aresetn(aresetn), .spi(i_tssr_spi_if_b),
		.sample_stb(stb), .supply_in(sup), .aux_in(aux), .temp_in(tmp), .tilt_full_in(tf),
		.tilt_signed_in(ts), .alarm_in(alarm), .wr_stb(wr_stb2), .wr_addr(wr_addr2),
		.wr_data(wr_data2));
	tssr_monitor i_tssr_monitor (.aclk(aclk), .aresetn(aresetn), .cs_n(i_tssr_spi_if.cs_n),
		.sclk(i_tssr_spi_if.sclk), .mosi(i_tssr_spi_if.mosi), .miso_o(i_tssr_spi_if.miso_o),
		.miso_oe(i_tssr_spi_if.miso_oe), .miso(i_tssr_spi_if.miso));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task print_verdict();
		if (error_cnt == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (!dd && wready === 1'b1) begin
				wvalid <= 1'b0;
				dd = 1'b1;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Starts one frame, waits out the busy flag, then fetches what came back.
	task xfer(input logic [15:0] t, output logic [15:0] rcv);
		axi_wr(REG_TX_WORD, {16'h0000, t}, r);
		d = 32'h1;
		while (d[0] !== 1'b0)
			axi_rd(REG_STATUS, d, r);
		axi_rd(REG_RX_WORD, d, r);
		rcv = d[15:0];
	endtask : xfer

	// Drives the second link by hand with any number of clocks, selected or not.
	task raw(input int n, input logic [15:0] w, input logic sel);
		i_tssr_spi_if_b.cs_n <= ~sel;
		repeat (8) @(posedge aclk);
		for (int i = 0; i < n; i++) begin
			i_tssr_spi_if_b.sclk <= 1'b0;
			i_tssr_spi_if_b.mosi <= w[15 - i];
			repeat (8) @(posedge aclk);
			i_tssr_spi_if_b.sclk <= 1'b1;
			repeat (8) @(posedge aclk);
		end
		i_tssr_spi_if_b.cs_n <= 1'b1;
		repeat (40) @(posedge aclk);
	endtask : raw

	function automatic logic [15:0] exp_word(input int j);
		case (j)
			0: exp_word = {1'b1, alarm, 2'b00, sup};
			1: exp_word = {1'b1, alarm, 2'b00, aux};
			2: exp_word = {1'b1, alarm, 2'b00, tmp};
			3: exp_word = {1'b1, alarm, tf};
			4: exp_word = {1'b1, alarm, ts};
			5: exp_word = {1'b0, alarm, 2'b00, sup};
			default: exp_word = 16'h0000;
		endcase
	endfunction : exp_word

	initial begin
		repeat (50000) @(posedge aclk);
		error_cnt++;
		print_verdict();
	end

	initial begin
		seed = 39;
		i_tssr_spi_if_b.cs_n = 1'b1;
		i_tssr_spi_if_b.sclk = 1'b1;
		i_tssr_spi_if_b.mosi = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		for (int p = 0; p < 2; p++) begin
			sup <= 12'($random(seed));
			aux <= 12'($random(seed));
			tmp <= 12'($random(seed));
			tf <= 14'($random(seed));
			ts <= (p == 0) ? 14'h3FE7 : 14'h0019;
			alarm <= p[0];
			wd = 8'($random(seed));
			stb <= 1'b1;
			@(posedge aclk);
			stb <= 1'b0;
			// Pipelined reads: each frame returns the register named in the one before.
			for (int k = 0; k < 8; k++) begin
				if (k == 7)
					tx = {CMD_WRITE, 6'h31 - 6'(p), wd};
				else
					tx = {CMD_READ, addr_t[k], 8'($random(seed))};
				xfer(tx, rx);
				if (k > 0)
					chk(32'(rx), 32'(exp_word(k - 1)));
			end
			chk(32'(wr_addr), 32'(6'h31 - 6'(p)));
			chk(32'(wr_data), 32'(wd));
			chk(32'(wr_cnt), 32'(p + 1));
		end
		axi_rd(8'h0C, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		axi_wr(8'h10, 32'h1234, r);
		chk(32'(r), 32'(RESP_SLVERR));
		raw(16, {CMD_WRITE, 6'h21, 8'hA5}, 1'b1);
		chk(32'(wr_cnt2), 32'h1);
		chk(32'(wr_addr2), 32'h21);
		chk(32'(wr_data2), 32'hA5);
		raw(15, {CMD_WRITE, 6'h22, 8'h5A}, 1'b1);
		chk(32'(wr_cnt2), 32'h1);
		raw(16, {CMD_WRITE, 6'h22, 8'h5A}, 1'b0);
		chk(32'(wr_cnt2), 32'h1);
		chk(32'(i_tssr_spi_if_b.miso_oe), 32'h0);
		print_verdict();
	end
endmodule : tssr_tb
`default_nettype wire
